// ==== src/urxb_map.svh ====
// register offsets, reset values and command codes of the receive control block
`ifndef URXB_MAP_SVH
`define URXB_MAP_SVH
`define URXB_OFF_MODE     8'h00
`define URXB_OFF_STATUS   8'h04
`define URXB_OFF_CMD      8'h08
`define URXB_OFF_RXPORT   8'h0C
`define URXB_OFF_ISR      8'h10
`define URXB_OFF_IMR      8'h14
`define URXB_OFF_PRE_HI   8'h18
`define URXB_OFF_PRE_LO   8'h1C
`define URXB_OFF_CTCMD    8'h20
`define URXB_OFF_CTVAL    8'h24
`define URXB_MODE_RTS     7
`define URXB_MODE_PAR_HI  4
`define URXB_MODE_PAR_LO  3
`define URXB_MODE_ADTAG   2
`define URXB_PAR_MULTIDROP 2'h3
`define URXB_CMD_RX_EN    0
`define URXB_CMD_RX_DIS   1
`define URXB_CMD_RX_RESET 4'h2
`define URXB_CMD_ERR_RST  4'h4
`define URXB_CMD_TMO_ON   4'hA
`define URXB_CMD_TMO_OFF  4'hC
`define URXB_CTCMD_START  0
`define URXB_CTCMD_STOP   1
`define URXB_ISR_CTRDY    3
`define URXB_FIFO_FULL    2'h3
`define URXB_PTR_LAST     2'h2
`define URXB_RST_MODE     8'h00
`define URXB_RST_MASK     8'h00
`define URXB_RST_PRESET   8'h00
`define URXB_RESP_OKAY    2'h0
`define URXB_RESP_SLVERR  2'h2
`endif

// ==== src/urxb_pkg.sv ====
// types of the receive control block
package urxb_pkg;
  typedef enum logic [1:0] {CT_IDLE, CT_RELOAD, CT_ARM, CT_RUN} urxb_ct_e;

  // one received character with its per-character status
  typedef struct packed {
    logic       brk;
    logic       frame;
    logic       tag;
    logic [7:0] data;
  } urxb_char_s;

  typedef struct packed {
    logic                 awready;
    logic                 wready;
    logic                 bvalid;
    logic [1:0]           bresp;
    logic                 arready;
    logic                 rvalid;
    logic [1:0]           rresp;
    logic [31:0]          rdata;
    logic                 aw_got;
    logic                 w_got;
    logic [7:0]           awaddr;
    logic [7:0]           wdata;
    logic                 wstrb0;
    logic [7:0]           mode;
    logic                 rx_en;
    logic                 armed;
    logic                 tmo;
    logic [7:0]           mask;
    logic [7:0]           pre_hi;
    logic [7:0]           pre_lo;
    logic [15:0]          ct_val;
    urxb_ct_e             ct_ph;
    logic                 ct_ready;
    logic                 irq;
    urxb_char_s [2:0]     mem;
    logic [1:0]           rd;
    logic [1:0]           wr;
    logic [1:0]           cnt;
    logic                 park;
    urxb_char_s           park_ent;
    logic                 ovr;
    logic                 rts_n;
    logic                 ad_tag_tx;
  } urxb_state_s;
endpackage

// ==== src/urxb_top.sv ====
// receive fifo control, overrun, rts flow control, timeout counter and multidrop
//
// The AXI4-Lite register port and the register addresses are this design's own decisions.
`include "urxb_map.svh"
module urxb_top
  import urxb_pkg::*;
(
  input  wire logic        SYS_CLK,
  input  wire logic        RESET,
  input  wire logic        CLK_EN,
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  input  wire logic        RX_START,
  input  wire logic        RX_DONE,
  input  wire urxb_char_s  RX_CHAR,
  input  wire logic        CT_TICK,
  output logic             REQUEST_TO_SEND_OUT_N,
  output logic             COUNTER_IRQ,
  output logic             AD_TAG_TX
);

  urxb_state_s s;
  urxb_state_s next_s;

  function automatic logic [1:0] inc3(input logic [1:0] p);
    inc3 = (p == `URXB_PTR_LAST) ? 2'h0 : p + 2'h1;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a <= `URXB_OFF_CTVAL) && (a[1:0] == 2'h0);
  endfunction

  logic       do_wr;
  logic       wr_ok;
  logic       cmd_wr;
  logic [3:0] cmd_code;
  logic       ar_fire;
  logic       pop;
  logic       st_rd;
  logic       multidrop;
  logic       full;

  assign do_wr     = s.aw_got & s.w_got & ~s.bvalid;
  assign wr_ok     = do_wr & s.wstrb0;
  assign cmd_wr    = wr_ok & (s.awaddr == `URXB_OFF_CMD);
  assign cmd_code  = s.wdata[7:4];
  assign ar_fire   = S_AXI_ARVALID & s.arready;
  assign pop       = ar_fire & (S_AXI_ARADDR == `URXB_OFF_RXPORT);
  assign st_rd     = ar_fire & (S_AXI_ARADDR == `URXB_OFF_STATUS);
  assign multidrop = (s.mode[`URXB_MODE_PAR_HI:`URXB_MODE_PAR_LO] == `URXB_PAR_MULTIDROP);
  assign full      = (s.cnt == `URXB_FIFO_FULL);

  always_comb begin
    logic       new_char;
    logic       from_park;
    logic       expire;
    logic       ovr_set;
    urxb_char_s top;
    new_char  = 1'b0;
    from_park = 1'b0;
    expire    = 1'b0;
    ovr_set   = 1'b0;
    top       = s.mem[s.rd];
    next_s    = s;

    // write channel: address and data taken in either order
    if (S_AXI_AWVALID && s.awready) begin
      next_s.aw_got  = 1'b1;
      next_s.awready = 1'b0;
      next_s.awaddr  = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && s.wready) begin
      next_s.w_got  = 1'b1;
      next_s.wready = 1'b0;
      next_s.wdata  = S_AXI_WDATA[7:0];
      next_s.wstrb0 = S_AXI_WSTRB[0];
    end
    if (do_wr) begin
      next_s.bvalid = 1'b1;
      next_s.bresp  = mapped(s.awaddr) ? `URXB_RESP_OKAY : `URXB_RESP_SLVERR;
    end
    if (s.bvalid && S_AXI_BREADY) begin
      next_s.bvalid  = 1'b0;
      next_s.aw_got  = 1'b0;
      next_s.w_got   = 1'b0;
      next_s.awready = 1'b1;
      next_s.wready  = 1'b1;
    end

    // read channel; only the receive port has a side effect
    if (ar_fire) begin
      next_s.arready = 1'b0;
      next_s.rvalid  = 1'b1;
      next_s.rresp   = mapped(S_AXI_ARADDR) ? `URXB_RESP_OKAY : `URXB_RESP_SLVERR;
      case (S_AXI_ARADDR)
        `URXB_OFF_MODE:   next_s.rdata = {24'h00_0000, s.mode};
        `URXB_OFF_STATUS: next_s.rdata = {24'h00_0000, top.brk, top.frame, top.tag,
                                          s.ovr, 2'h0, full, s.cnt != 2'h0};
        `URXB_OFF_RXPORT: next_s.rdata = {24'h00_0000, top.data};
        `URXB_OFF_ISR:    next_s.rdata = {28'h000_0000, s.ct_ready, 3'h0};
        `URXB_OFF_IMR:    next_s.rdata = {24'h00_0000, s.mask};
        `URXB_OFF_PRE_HI: next_s.rdata = {24'h00_0000, s.pre_hi};
        `URXB_OFF_PRE_LO: next_s.rdata = {24'h00_0000, s.pre_lo};
        `URXB_OFF_CTVAL:  next_s.rdata = {16'h0000, s.ct_val};
        default:          next_s.rdata = 32'h0000_0000;
      endcase
    end
    if (s.rvalid && S_AXI_RREADY) begin
      next_s.rvalid  = 1'b0;
      next_s.arready = 1'b1;
    end

    // stale data stays; pointer moves even when empty
    if (pop) begin
      next_s.rd = inc3(s.rd);
      if (s.cnt != 2'h0) begin
        next_s.cnt = s.cnt - 2'h1;
      end
    end

    // a start only counts while listening; multidrop listens even disabled
    if (RX_START && (s.rx_en || multidrop)) begin
      next_s.armed = 1'b1;
    end
    if (RX_DONE && s.armed) begin
      new_char = s.rx_en || RX_CHAR.tag || !multidrop;
      new_char = new_char && (s.rx_en || multidrop);
    end

    if (s.park && next_s.cnt != `URXB_FIFO_FULL) begin
      next_s.mem[next_s.wr] = s.park_ent;
      next_s.wr   = inc3(next_s.wr);
      next_s.cnt  = next_s.cnt + 2'h1;
      next_s.park = 1'b0;
      from_park   = 1'b1;
    end
    if (RX_START && s.park && !from_park) begin
      next_s.park = 1'b0;
      next_s.ovr  = 1'b1;
      ovr_set     = 1'b1;
    end
    if (new_char) begin
      if (next_s.cnt != `URXB_FIFO_FULL && !next_s.park) begin
        next_s.mem[next_s.wr] = RX_CHAR;
        next_s.wr  = inc3(next_s.wr);
        next_s.cnt = next_s.cnt + 2'h1;
      end else begin
        next_s.park     = 1'b1;
        next_s.park_ent = RX_CHAR;
      end
    end

    // counter: one tick to stop and reload, the next to restart
    if (CT_TICK) begin
      case (s.ct_ph)
        CT_RELOAD: begin
          next_s.ct_val = {s.pre_hi, s.pre_lo};
          next_s.ct_ph  = CT_ARM;
        end
        CT_ARM:    next_s.ct_ph = CT_RUN;
        CT_RUN: begin
          if (s.ct_val <= 16'h0001) begin
            next_s.ct_val   = 16'h0000;
            next_s.ct_ready = 1'b1;
            next_s.ct_ph    = CT_IDLE;
            expire          = 1'b1;
          end else begin
            next_s.ct_val = s.ct_val - 16'h0001;
          end
        end
        CT_IDLE:   next_s.ct_ph = CT_IDLE;
        default:   next_s.ct_ph = CT_IDLE;
      endcase
    end
    if (s.tmo && (from_park || (new_char && next_s.wr != s.wr))) begin
      next_s.ct_ph = CT_RELOAD;
      if (!expire) begin
        next_s.ct_ready = 1'b0;
      end
    end

    // register writes win over the receive path, except a same-cycle overrun or counter expiry
    if (wr_ok) begin
      case (s.awaddr)
        `URXB_OFF_MODE:   next_s.mode   = s.wdata;
        `URXB_OFF_IMR:    next_s.mask   = s.wdata;
        `URXB_OFF_PRE_HI: next_s.pre_hi = s.wdata;
        `URXB_OFF_PRE_LO: next_s.pre_lo = s.wdata;
        `URXB_OFF_CTCMD: begin
          // shared counter belongs to the receiver in timeout mode
          if (!s.tmo && s.wdata[`URXB_CTCMD_START]) begin
            next_s.ct_val = {s.pre_hi, s.pre_lo};
            next_s.ct_ph  = CT_RUN;
          end else if (!s.tmo && s.wdata[`URXB_CTCMD_STOP]) begin
            next_s.ct_ph = CT_IDLE;
            if (!expire) begin
              next_s.ct_ready = 1'b0;
            end
          end
        end
        default: next_s.mode = next_s.mode;
      endcase
    end
    if (cmd_wr) begin
      if (s.wdata[`URXB_CMD_RX_EN]) begin
        next_s.rx_en = 1'b1;
      end
      if (s.wdata[`URXB_CMD_RX_DIS]) begin
        next_s.rx_en = 1'b0;
        next_s.armed = 1'b0;
      end
      case (cmd_code)
        `URXB_CMD_RX_RESET: begin
          next_s.rx_en = 1'b0;
          next_s.armed = 1'b0;
          next_s.park  = 1'b0;
          next_s.ovr   = ovr_set;
          next_s.rd    = s.wr;
          next_s.wr    = s.wr;
          next_s.cnt   = 2'h0;
          next_s.mem[s.wr].brk   = 1'b0;
          next_s.mem[s.wr].frame = 1'b0;
          next_s.mem[s.wr].tag   = 1'b0;
        end
        // an overrun in the same cycle as the clear survives it
        `URXB_CMD_ERR_RST: next_s.ovr = ovr_set;
        `URXB_CMD_TMO_ON: begin
          next_s.tmo   = 1'b1;
          next_s.ct_ph = CT_IDLE;
          if (!expire) begin
            next_s.ct_ready = 1'b0;
          end
        end
        `URXB_CMD_TMO_OFF: next_s.tmo = 1'b0;
        default:           next_s.tmo = next_s.tmo;
      endcase
    end

    // flow control: negate wins over reassert in one cycle
    if (!next_s.mode[`URXB_MODE_RTS]) begin
      next_s.rts_n = 1'b0;
    end else if (RX_START && full) begin
      next_s.rts_n = 1'b1;
    end else if (next_s.cnt != `URXB_FIFO_FULL) begin
      next_s.rts_n = 1'b0;
    end
    next_s.irq = next_s.ct_ready & next_s.mask[`URXB_ISR_CTRDY];
    next_s.ad_tag_tx = (next_s.mode[`URXB_MODE_PAR_HI:`URXB_MODE_PAR_LO] == `URXB_PAR_MULTIDROP)
                       & next_s.mode[`URXB_MODE_ADTAG];
  end

  always_ff @(posedge SYS_CLK) begin
    if (RESET) begin
      s          <= '0;
      s.awready  <= 1'b1;
      s.wready   <= 1'b1;
      s.arready  <= 1'b1;
      s.mode     <= `URXB_RST_MODE;
      s.mask     <= `URXB_RST_MASK;
      s.pre_hi   <= `URXB_RST_PRESET;
      s.pre_lo   <= `URXB_RST_PRESET;
      s.ct_ph    <= CT_IDLE;
    end else if (CLK_EN) begin
      s <= next_s;
    end
  end

  assign S_AXI_AWREADY         = s.awready;
  assign S_AXI_WREADY          = s.wready;
  assign S_AXI_BVALID          = s.bvalid;
  assign S_AXI_BRESP           = s.bresp;
  assign S_AXI_ARREADY         = s.arready;
  assign S_AXI_RVALID          = s.rvalid;
  assign S_AXI_RRESP           = s.rresp;
  assign S_AXI_RDATA           = s.rdata;
  assign REQUEST_TO_SEND_OUT_N = s.rts_n;
  assign COUNTER_IRQ           = s.irq;
  assign AD_TAG_TX             = s.ad_tag_tx;

  sequence q_reload;
    CLK_EN && CT_TICK && s.ct_ph == CT_RELOAD ##1 s.ct_ph == CT_ARM;
  endsequence

  property p_status_keeps;
    @(posedge SYS_CLK) disable iff (RESET)
      CLK_EN && st_rd |=> s.rd == $past(s.rd);
  endproperty
  a_status_keeps: assert property (p_status_keeps) else $error("status read moved fifo");

  property p_pop_moves;
    @(posedge SYS_CLK) disable iff (RESET)
      CLK_EN && pop && !cmd_wr |=> s.rd == inc3($past(s.rd));
  endproperty
  a_pop_moves: assert property (p_pop_moves) else $error("port read did not pop");

  property p_park;
    @(posedge SYS_CLK) disable iff (RESET)
      CLK_EN && RX_DONE && s.armed && s.rx_en && full && !s.park && !pop && !cmd_wr
      |=> s.park && s.park_ent == $past(RX_CHAR);
  endproperty
  a_park: assert property (p_park) else $error("character not parked");

  property p_overrun;
    @(posedge SYS_CLK) disable iff (RESET)
      CLK_EN && RX_START && !RX_DONE && s.park && full && !pop && !cmd_wr
      |=> s.ovr && !s.park;
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun not flagged");

  property p_rts_neg;
    @(posedge SYS_CLK) disable iff (RESET)
      CLK_EN && next_s.mode[`URXB_MODE_RTS] && RX_START && full |=> REQUEST_TO_SEND_OUT_N;
  endproperty
  a_rts_neg: assert property (p_rts_neg) else $error("rts not negated");

  property p_rts_back;
    @(posedge SYS_CLK) disable iff (RESET)
      CLK_EN && REQUEST_TO_SEND_OUT_N && !RX_START && next_s.cnt != `URXB_FIFO_FULL
      |=> !REQUEST_TO_SEND_OUT_N;
  endproperty
  a_rts_back: assert property (p_rts_back) else $error("rts not reasserted");

  property p_disable;
    @(posedge SYS_CLK) disable iff (RESET)
      CLK_EN && cmd_wr && s.wdata[`URXB_CMD_RX_DIS] |=> !s.rx_en && !s.armed;
  endproperty
  a_disable: assert property (p_disable) else $error("disable did not stop receiver");

  property p_rx_reset;
    @(posedge SYS_CLK) disable iff (RESET)
      CLK_EN && cmd_wr && cmd_code == `URXB_CMD_RX_RESET
      |=> s.cnt == 2'h0 && s.rd == s.wr && !s.park;
  endproperty
  a_rx_reset: assert property (p_rx_reset) else $error("receiver reset incomplete");

  property p_tmo_on;
    @(posedge SYS_CLK) disable iff (RESET)
      CLK_EN && cmd_wr && cmd_code == `URXB_CMD_TMO_ON && !(CT_TICK && s.ct_ph == CT_RUN)
      |=> s.tmo && !s.ct_ready && s.ct_ph == CT_IDLE;
  endproperty
  a_tmo_on: assert property (p_tmo_on) else $error("timeout on not clean");

  property p_reload;
    @(posedge SYS_CLK) disable iff (RESET)
      q_reload |-> s.ct_val == {$past(s.pre_hi), $past(s.pre_lo)};
  endproperty
  a_reload: assert property (p_reload) else $error("counter not reloaded");

  property p_irq;
    @(posedge SYS_CLK) disable iff (RESET)
      CLK_EN && CT_TICK && s.ct_ph == CT_RUN && s.ct_val <= 16'h0001
      |=> s.ct_ready && COUNTER_IRQ == s.mask[`URXB_ISR_CTRDY];
  endproperty
  a_irq: assert property (p_irq) else $error("expiry did not set ready and irq");

endmodule // urxb_top

// ==== tb/urxb_far_tx.sv ====
// behavioural far-side transmitter: start pulse, a gap, then the finished character
module urxb_far_tx
  import urxb_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       go,
  input  wire logic [3:0] gap,
  input  wire urxb_char_s ch,
  output logic            rx_start,
  output logic            rx_done,
  output urxb_char_s      rx_char,
  output logic            busy
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] left = 4'h0;
  urxb_char_s last = '0;
  initial begin
    rx_start = 1'h0;
    rx_done = 1'h0;
    rx_char = '1;
    busy = 1'h0;
  end
  // payload means nothing outside the done pulse, so it keeps toggling there
  always @(posedge clk) begin
    rx_start <= 1'h0;
    rx_done <= 1'h0;
    rx_char <= ~rx_char;
    if (go && !busy) begin
      rx_start <= 1'h1;
      left <= gap;
      last <= ch;
      busy <= 1'h1;
    end else if (busy && left == 4'h0) begin
      rx_done <= 1'h1;
      rx_char <= last;
      busy <= 1'h0;
    end else if (busy) begin
      left <= left - 4'h1;
    end
  end
endmodule // urxb_far_tx

// ==== tb/uart_rx_buffer_timeout_multidrop_bench.sv ====
// self-checking bench of the receive control block
`include "urxb_map.svh"
module uart_rx_buffer_timeout_multidrop_bench
  import urxb_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic [7:0] mode;
    logic [7:0] cmd;
    urxb_char_s c;
    logic [7:0] st;
    logic       adtx;
  } urxb_row_s;
  // mode, command, character {brk,frame,tag,data}, expected status, expected tag out
  localparam urxb_row_s rows [8] = '{
    '{8'h00, 8'h01, 11'h05A, 8'h01, 1'h0}, '{8'h00, 8'h01, 11'h7C3, 8'hE1, 1'h0},
    '{8'h0C, 8'h01, 11'h144, 8'h21, 1'h0}, '{8'h18, 8'h01, 11'h033, 8'h01, 1'h0},
    '{8'h18, 8'h01, 11'h2C5, 8'h41, 1'h0}, '{8'h1C, 8'h01, 11'h1A5, 8'h21, 1'h1},
    '{8'h18, 8'h02, 11'h5B6, 8'hA1, 1'h0}, '{8'h18, 8'h02, 11'h0B7, 8'h00, 1'h0}};
  localparam logic [7:0] zero_offs [6] = '{`URXB_OFF_MODE, `URXB_OFF_STATUS,
    `URXB_OFF_ISR, `URXB_OFF_IMR, `URXB_OFF_PRE_HI, `URXB_OFF_PRE_LO};
  localparam logic [7:0] drain [4] = '{8'h11, 8'h22, 8'h33, 8'h55};
  logic        clk = 1'h0;
  logic        rst = 1'h1;
  logic        clk_en = 1'h1;
  logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic        arvalid = 1'h0, rready = 1'h0, ct_tick = 1'h0, go = 1'h0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0]  gap = 4'h0;
  logic [1:0]  tick_div = 2'h0;
  urxb_char_s  ch = '0;
  urxb_char_s  rx_char;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        rts_n, irq, adtx, rx_start, rx_done, busy;
  logic [1:0]  bresp, rresp, r;
  logic [31:0] rdata, q;
  int          n_fail = 0;
  int          num_checks = 0;

  urxb_top urxb_top_inst (
    .SYS_CLK(clk), .RESET(rst), .CLK_EN(clk_en),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .RX_START(rx_start), .RX_DONE(rx_done), .RX_CHAR(rx_char), .CT_TICK(ct_tick),
    .REQUEST_TO_SEND_OUT_N(rts_n), .COUNTER_IRQ(irq), .AD_TAG_TX(adtx)
  );
  urxb_far_tx urxb_far_tx_inst (
    .clk(clk), .go(go), .gap(gap), .ch(ch), .rx_start(rx_start), .rx_done(rx_done),
    .rx_char(rx_char), .busy(busy)
  );

  always #5 clk = ~clk;
  // counter clock every fourth cycle, far slower than the bus
  always @(posedge clk) begin
    tick_div <= tick_div + 2'h1;
    ct_tick <= (tick_div == 2'h3);
  end

  task automatic stop_test();
    $display("checks %0d, failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tmo(input int n);
    if (n >= 60) begin
      n_fail++;
      $display("[ERR] handshake expected within 60 cycles seen none");
      stop_test();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = 2'h0);
    int n;
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (n = 0; n < 60; n++) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
      if (bvalid) break;
    end
    bready <= 1'h0;
    tmo(n);
    chk("write response", 32'(er), 32'(bresp));
  endtask
  task automatic rd(input logic [7:0] a);
    int n;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (n = 0; n < 60; n++) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'h0;
      if (rvalid) break;
    end
    rready <= 1'h0;
    q = rdata;
    r = rresp;
    tmo(n);
  endtask
  task automatic rc(input string nm, input logic [7:0] a, input logic [7:0] e);
    rd(a);
    chk(nm, 32'(e), q);
  endtask
  task automatic send(input urxb_char_s c, input logic [3:0] g);
    @(posedge clk);
    ch <= c;
    gap <= g;
    go <= 1'h1;
    @(posedge clk);
    go <= 1'h0;
  endtask
  task automatic idle();
    int n;
    for (n = 0; n < 60; n++) begin
      @(posedge clk);
      if (!busy && !go) break;
    end
    tmo(n);
  endtask
  function automatic urxb_char_s mk(input logic [7:0] d);
    return {3'h0, d};
  endfunction

  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'h0;
    foreach (rows[i]) begin
      wr(`URXB_OFF_MODE, rows[i].mode);
      wr(`URXB_OFF_CMD, rows[i].cmd);
      send(rows[i].c, 4'h2);
      idle();
      rc("status", `URXB_OFF_STATUS, rows[i].st);
      if (rows[i].st[0]) rc("rx data", `URXB_OFF_RXPORT, rows[i].c.data);
      chk("tag out", 32'(rows[i].adtx), 32'(adtx));
      wr(`URXB_OFF_CMD, 8'h20);
    end
    // second reset in mid-run
    wr(`URXB_OFF_MODE, 8'h1C);
    wr(`URXB_OFF_IMR, 8'h5A);
    rst <= 1'h1;
    repeat (8) @(posedge clk);
    chk("rts reset", 32'(1'h0), 32'(rts_n));
    chk("irq reset", 32'(1'h0), 32'(irq));
    chk("tag reset", 32'(1'h0), 32'(adtx));
    rst <= 1'h0;
    foreach (zero_offs[i]) rc("reset value", zero_offs[i], 8'h00);
    rd(8'h28);
    chk("unmapped read", 32'(`URXB_RESP_SLVERR), 32'(r));
    chk("unmapped data", 32'h0000_0000, q);
    wr(8'h30, 8'h01, `URXB_RESP_SLVERR);
    // fill, park one, overrun it, drain, over-read, then realign
    wr(`URXB_OFF_MODE, 8'h80);
    wr(`URXB_OFF_CMD, 8'h01);
    for (int i = 1; i < 4; i++) begin
      send(mk(8'(8'h11 * i)), 4'h2);
      idle();
    end
    rc("full status", `URXB_OFF_STATUS, 8'h03);
    rc("status reread", `URXB_OFF_STATUS, 8'h03);
    chk("rts while full", 32'(1'h0), 32'(rts_n));
    send(mk(8'h44), 4'h6);
    repeat (3) @(posedge clk);
    chk("rts on start", 32'(1'h1), 32'(rts_n));
    idle();
    rc("parked status", `URXB_OFF_STATUS, 8'h03);
    send(mk(8'h55), 4'h6);
    repeat (3) @(posedge clk);
    rc("overrun status", `URXB_OFF_STATUS, 8'h13);
    idle();
    foreach (drain[i]) rc("drain", `URXB_OFF_RXPORT, drain[i]);
    chk("rts after drain", 32'(1'h0), 32'(rts_n));
    rc("over-read", `URXB_OFF_RXPORT, 8'h22);
    rc("empty status", `URXB_OFF_STATUS, 8'h10);
    wr(`URXB_OFF_CMD, 8'h40);
    rc("error reset", `URXB_OFF_STATUS, 8'h00);
    wr(`URXB_OFF_CMD, 8'h20);
    rc("status after reset", `URXB_OFF_STATUS, 8'h00);
    wr(`URXB_OFF_CMD, 8'h01);
    send(mk(8'h66), 4'h2);
    idle();
    rc("realigned data", `URXB_OFF_RXPORT, 8'h66);
    // disable and re-enable while a character is on the line
    send(mk(8'h77), 4'h2);
    idle();
    send(mk(8'h88), 4'hF);
    wr(`URXB_OFF_CMD, 8'h02);
    idle();
    rc("kept status", `URXB_OFF_STATUS, 8'h01);
    rc("kept data", `URXB_OFF_RXPORT, 8'h77);
    send(mk(8'h99), 4'hF);
    wr(`URXB_OFF_CMD, 8'h01);
    idle();
    rc("late start dropped", `URXB_OFF_STATUS, 8'h00);
    send(mk(8'hAA), 4'h2);
    idle();
    rc("next start taken", `URXB_OFF_RXPORT, 8'hAA);
    // receive timeout on the shared counter
    wr(`URXB_OFF_PRE_HI, 8'h00);
    wr(`URXB_OFF_PRE_LO, 8'h05);
    wr(`URXB_OFF_IMR, 8'h08);
    wr(`URXB_OFF_CMD, 8'hA0);
    wr(`URXB_OFF_CTCMD, 8'h01);
    repeat (60) @(posedge clk);
    rc("isr held", `URXB_OFF_ISR, 8'h00);
    send(mk(8'h31), 4'h2);
    idle();
    rc("isr counting", `URXB_OFF_ISR, 8'h00);
    repeat (60) @(posedge clk);
    rc("isr expired", `URXB_OFF_ISR, 8'h08);
    chk("irq", 32'(1'h1), 32'(irq));
    wr(`URXB_OFF_IMR, 8'h00);
    repeat (2) @(posedge clk);
    chk("irq masked", 32'(1'h0), 32'(irq));
    wr(`URXB_OFF_IMR, 8'h08);
    send(mk(8'h32), 4'h2);
    idle();
    repeat (2) @(posedge clk);
    rc("isr after char", `URXB_OFF_ISR, 8'h00);
    chk("irq withdrawn", 32'(1'h0), 32'(irq));
    wr(`URXB_OFF_CTCMD, 8'h02);
    repeat (60) @(posedge clk);
    rc("isr expired again", `URXB_OFF_ISR, 8'h08);
    wr(`URXB_OFF_CMD, 8'hA0);
    repeat (60) @(posedge clk);
    rc("isr after on", `URXB_OFF_ISR, 8'h00);
    wr(`URXB_OFF_CMD, 8'hC0);
    send(mk(8'h33), 4'h2);
    idle();
    repeat (60) @(posedge clk);
    rc("isr mode off", `URXB_OFF_ISR, 8'h00);
    // ordinary counter outside timeout mode; frozen while the clock enable is low
    wr(`URXB_OFF_CTCMD, 8'h01);
    clk_en <= 1'h0;
    repeat (60) @(posedge clk);
    clk_en <= 1'h1;
    rc("isr frozen", `URXB_OFF_ISR, 8'h00);
    repeat (60) @(posedge clk);
    rc("isr counter run", `URXB_OFF_ISR, 8'h08);
    rc("counter at zero", `URXB_OFF_CTVAL, 8'h00);
    wr(`URXB_OFF_CTCMD, 8'h02);
    rc("isr counter stop", `URXB_OFF_ISR, 8'h00);
    stop_test();
  end
endmodule // uart_rx_buffer_timeout_multidrop_bench
